//--- erb_asserts.sv
// erb_asserts: port checks bound to every ram block instance.
// assumes: one clock, rstn synchronous active low, no output registers.
`timescale 1ns/1ps
// ==========
// checker
module erb_asserts #(
  parameter erb_pkg::erb_mode_e  MODE    = erb_pkg::MODE_TRUE_DUAL,
  parameter erb_pkg::erb_wmode_e WMODE_A = erb_pkg::WR_NORMAL
) (
  // clock and reset
  input wire logic                         ref_clk,
  input wire logic                         rstn,
  // requests
  input wire erb_pkg::erb_port_req_s       port_a,
  input wire erb_pkg::erb_port_req_s       port_b,
  input wire erb_pkg::erb_fifo_ctl_s       fifo_ctl,
  // answers
  input wire logic [erb_pkg::DATA_W-1:0]   a_rdata,
  input wire logic [erb_pkg::DATA_W-1:0]   b_rdata,
  input wire logic                         b_rvalid,
  input wire logic                         b_rready,
  input wire logic                         b_ready,
  input wire erb_pkg::erb_fifo_flags_s     fifo_flags
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  wire fifo = (MODE == erb_pkg::MODE_FIFO);  // flags only move in fifo form
  wire rd_b = port_b.clk_en && port_b.sel && !port_b.wr_en && b_ready;  // taken b read
  wire wr_f = fifo_ctl.write_port_select && fifo_ctl.write_select_alias && fifo_ctl.wr_en;
  property p_reset; $rose(rstn) |-> a_rdata == '0 && !b_rvalid && b_ready && fifo_flags == 4'h3; endproperty
  a_reset: assert property (p_reset) else $error("reset values wrong");
  property p_hold; !(port_a.clk_en && port_a.sel) |=> $stable(a_rdata); endproperty
  a_hold: assert property (p_hold) else $error("idle port a moved");
  property p_thru; WMODE_A == erb_pkg::WR_THROUGH && port_a.clk_en && port_a.sel && port_a.wr_en |=> a_rdata[8:0] == $past(port_a.write_word_in[8:0]); endproperty
  a_thru: assert property (p_thru) else $error("write data not shown");
  property p_lat; !fifo && rd_b && !b_rvalid |-> ##3 b_rvalid; endproperty
  a_lat: assert property (p_lat) else $error("b read late");
  property p_stall; b_rvalid && !b_rready |=> b_rvalid && $stable(b_rdata); endproperty
  a_stall: assert property (p_stall) else $error("stalled head moved");
  property p_idle; !fifo |-> fifo_flags == erb_pkg::FLAGS_RESET; endproperty
  a_idle: assert property (p_idle) else $error("flags moved outside fifo");
  property p_push; fifo && fifo_flags.empty_flag && !fifo_flags.full_flag && wr_f |-> ##1 !fifo_flags.empty_flag; endproperty
  a_push: assert property (p_push) else $error("empty not cleared");
  property p_order; (fifo_flags.empty_flag |-> fifo_flags.almost_empty_flag) and (fifo_flags.full_flag |-> fifo_flags.almost_full_flag); endproperty
  a_order: assert property (p_order) else $error("flag order wrong");
endmodule : erb_asserts
bind erb_embedded_ram_block erb_asserts #(.MODE(MODE), .WMODE_A(WMODE_A)) u_erb_asserts (
  .ref_clk(ref_clk), .rstn(rstn), .port_a(port_a), .port_b(port_b), .fifo_ctl(fifo_ctl),
  .a_rdata(a_rdata), .b_rdata(b_rdata), .b_rvalid(b_rvalid), .b_rready(b_rready),
  .b_ready(b_ready), .fifo_flags(fifo_flags));

//--- erb_embedded_ram_block.sv
// erb_embedded_ram_block: 9-Kbit block memory in single, dual, pseudo-dual or fifo
// form, with a 32-word stream buffer behind port b.
// assumes: user logic drives every control synchronously to ref_clk.

`timescale 1ns/1ps

// ============================================================================
// stream buffer: registered head word, back-pressure through in_ready
module erb_stream_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 32,
  parameter int SLACK = 3
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rstn,
  // filling side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // draining side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0]      count;                   // words in storage
    logic [PW-1:0]    wr_idx;                  // next slot to fill
    logic [PW-1:0]    rd_idx;                  // next slot to drain
    logic             head_valid;              // head register full
    logic [WIDTH-1:0] head;                    // word shown to the drain
    logic             ready;                   // room kept for in-flight words
  } erb_buf_state_s;

  erb_buf_state_s   cur;                        // registered state
  erb_buf_state_s   next_cur;                   // next state
  logic [WIDTH-1:0] store [DEPTH];             // word storage
  logic             take;                      // word accepted this cycle
  logic             pop;                       // storage to head this cycle

  // ==========================================================================
  // next state
  always_comb begin
    next_cur = cur;
    // a word offered while storage is full is dropped; the source sees in_ready
    take = in_valid && (cur.count < (PW+1)'(DEPTH));
    pop  = (cur.count != '0) && (!cur.head_valid || out_ready);
    if (take) begin
      next_cur.wr_idx = cur.wr_idx + 1'b1;
    end
    if (pop) begin
      next_cur.rd_idx     = cur.rd_idx + 1'b1;
      next_cur.head_valid = 1'b1;
      next_cur.head       = store[cur.rd_idx];
    end else if (out_ready) begin
      next_cur.head_valid = 1'b0;
    end
    next_cur.count = cur.count + (PW+1)'(take) - (PW+1)'(pop);
    // ready is registered, so the slack covers words already on their way
    next_cur.ready = next_cur.count <= (PW+1)'(DEPTH - SLACK);
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur       <= '0;
      cur.ready <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  // storage holds no reset; only the pointers define what is valid
  always_ff @(posedge ref_clk) begin
    if (take) begin
      store[cur.wr_idx] <= in_data;
    end
  end

  assign in_ready  = cur.ready;
  assign out_valid = cur.head_valid;
  assign out_data  = cur.head;

endmodule : erb_stream_fifo

// ============================================================================
// block memory
module erb_embedded_ram_block #(
  parameter erb_pkg::erb_mode_e             MODE      = erb_pkg::MODE_TRUE_DUAL,
  parameter int                             WIDTH_A   = 9,
  parameter int                             WIDTH_B   = 9,
  parameter erb_pkg::erb_wmode_e            WMODE_A   = erb_pkg::WR_NORMAL,
  parameter erb_pkg::erb_wmode_e            WMODE_B   = erb_pkg::WR_NORMAL,
  parameter bit                             OUT_REG_A = 1'b0,
  parameter bit                             OUT_REG_B = 1'b0,
  parameter logic [erb_pkg::CAP_BITS-1:0]   INIT      = '0
) (
  // clock and reset
  input  wire logic                      ref_clk,
  input  wire logic                      rstn,
  // random-access ports (port a is the fifo write side)
  input  wire erb_pkg::erb_port_req_s    port_a,
  input  wire erb_pkg::erb_port_req_s    port_b,
  // fifo controls and thresholds
  input  wire erb_pkg::erb_fifo_ctl_s    fifo_ctl,
  input  wire erb_pkg::erb_fifo_thr_s    fifo_thr,
  // port a read data
  output logic [erb_pkg::DATA_W-1:0]     a_rdata,
  // port b read data, through the stream buffer
  output logic [erb_pkg::DATA_W-1:0]     b_rdata,
  output logic                           b_rvalid,
  input  wire logic                      b_rready,
  output logic                           b_ready,
  // fifo status
  output erb_pkg::erb_fifo_flags_s       fifo_flags
);
  localparam int  IW       = erb_pkg::IDX_W;
  localparam int  DW       = erb_pkg::DATA_W;
  localparam int  FW       = erb_pkg::FILL_W;
  localparam int  CAP_A    = erb_pkg::depth_of(WIDTH_A) * WIDTH_A;
  localparam int  CAP_B    = erb_pkg::depth_of(WIDTH_B) * WIDTH_B;
  localparam int  FIFO_CAP = (CAP_A < CAP_B) ? CAP_A : CAP_B;
  localparam bit  IS_FIFO  = (MODE == erb_pkg::MODE_FIFO);
  localparam bit  A_READS  = (MODE == erb_pkg::MODE_SINGLE) ||
                             (MODE == erb_pkg::MODE_TRUE_DUAL);
  localparam bit  B_USED   = (MODE == erb_pkg::MODE_TRUE_DUAL) ||
                             (MODE == erb_pkg::MODE_PSEUDO_DUAL);
  localparam bit  B_WRITES = (MODE == erb_pkg::MODE_TRUE_DUAL);

  erb_pkg::erb_state_s      cur;                // registered state
  erb_pkg::erb_state_s      next_cur;           // next state
  logic [erb_pkg::CAP_BITS-1:0] mem = INIT;
  logic                     a_go;              // port a enabled
  logic                     a_wr;              // port a write
  logic                     a_rd;              // port a read
  logic                     b_go;              // port b enabled
  logic                     b_wr;              // port b write
  logic                     b_rd;              // port b read
  logic                     f_wr;              // fifo push
  logic                     f_rd;              // fifo pop
  logic                     b_made;            // port b output changed
  logic                     b_adv;             // port b output register advances
  logic [IW-1:0]            a_base;            // first bit of port a word
  logic [IW-1:0]            b_base;            // first bit of port b word
  logic [DW-1:0]            a_old;             // array contents at a_base
  logic [DW-1:0]            b_old;             // array contents at b_base
  logic [DW-1:0]            a_mask;            // bits written by port a
  logic [DW-1:0]            b_mask;            // bits written by port b
  logic [FW-1:0]            fill;              // bits held by the fifo
  logic [FW-1:0]            next_fill;         // fill after this edge
  logic                     room;              // a whole write word fits
  logic                     buf_ready;         // stream buffer has room

  // ==========================================================================
  // helpers
  // word of width w starting at bit base; bits above w read as zero
  function automatic logic [DW-1:0] word_at(input logic [erb_pkg::CAP_BITS-1:0] m,
                                            input logic [IW-1:0] base, input int w);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++) begin
      if (i < w && (int'(base) + i) < erb_pkg::CAP_BITS) begin
        r[i] = m[int'(base) + i];
      end
    end
    return r;
  endfunction : word_at

  // bits of a write, with byte lanes honoured only at full width
  function automatic logic [DW-1:0] lane_mask(input int w, input logic [1:0] lanes);
    logic [DW-1:0] r;
    r = '0;
    for (int i = 0; i < DW; i++) begin
      r[i] = (i < w) && ((w != DW) || lanes[i / erb_pkg::LANE_W]);
    end
    return r;
  endfunction : lane_mask

  // bits between two pointers, lap parity telling full from empty
  function automatic logic [FW-1:0] fill_of(input logic [IW-1:0] w, input logic [IW-1:0] r,
                                            input logic ww, input logic rw);
    if (ww == rw) begin
      return FW'(w) - FW'(r);
    end
    return FW'(FIFO_CAP) - FW'(r) + FW'(w);
  endfunction : fill_of

  // ==========================================================================
  // next state
  always_comb begin
    next_cur = cur;
    // a disabled port sees no request and its output stays put
    a_go = port_a.clk_en & port_a.sel;
    a_wr = a_go & port_a.wr_en & ~IS_FIFO;
    a_rd = a_go & ~port_a.wr_en & A_READS;
    b_go = port_b.clk_en & port_b.sel & buf_ready & B_USED;
    b_wr = b_go & port_b.wr_en & B_WRITES;
    b_rd = b_go & ~port_b.wr_en;
    fill = fill_of(cur.wptr, cur.rptr, cur.wwrap, cur.rwrap);
    room = (fill + FW'(WIDTH_A)) <= FW'(FIFO_CAP);
    // alias inputs are simply second selects on each fifo side
    f_wr = IS_FIFO & fifo_ctl.write_port_select & fifo_ctl.write_select_alias
         & fifo_ctl.wr_en & ~cur.flags.full_flag & room;
    f_rd = IS_FIFO & fifo_ctl.read_port_select & fifo_ctl.read_select_alias
         & fifo_ctl.rd_en & ~cur.flags.empty_flag & buf_ready;
    // word address scales by port width onto one shared bit array
    a_base = IS_FIFO ? cur.wptr : IW'(32'(port_a.addr) * WIDTH_A);
    b_base = IS_FIFO ? cur.rptr : IW'(32'(port_b.addr) * WIDTH_B);
    a_old  = word_at(mem, a_base, WIDTH_A);
    b_old  = word_at(mem, b_base, WIDTH_B);
    a_mask = lane_mask(WIDTH_A, port_a.byte_lane_enable) & {DW{a_wr | f_wr}};
    b_mask = lane_mask(WIDTH_B, port_b.byte_lane_enable) & {DW{b_wr}};

    // port a output, behaviour per write mode
    if (a_rd) begin
      next_cur.a_latch = a_old;
    end else if (a_wr) begin
      case (WMODE_A)
        erb_pkg::WR_THROUGH: begin
          next_cur.a_latch = port_a.write_word_in & lane_mask(WIDTH_A, 2'h3);
        end
        erb_pkg::WR_READ_FIRST: begin
          next_cur.a_latch = a_old;
        end
        default: begin
          next_cur.a_latch = cur.a_latch;
        end
      endcase
    end
    if (port_a.clk_en && port_a.output_register_enable) begin
      next_cur.a_oreg = cur.a_latch;
    end

    // port b output, also carries fifo reads
    b_made = 1'b0;
    if (b_rd || f_rd) begin
      next_cur.b_latch = b_old;
      b_made           = 1'b1;
    end else if (b_wr) begin
      case (WMODE_B)
        erb_pkg::WR_THROUGH: begin
          next_cur.b_latch = port_b.write_word_in & lane_mask(WIDTH_B, 2'h3);
          b_made           = 1'b1;
        end
        erb_pkg::WR_READ_FIRST: begin
          next_cur.b_latch = b_old;
          b_made           = 1'b1;
        end
        default: begin
          next_cur.b_latch = cur.b_latch;
        end
      endcase
    end
    b_adv = IS_FIFO ? fifo_ctl.output_read_enable
                    : (port_b.clk_en & port_b.output_register_enable);
    if (b_adv) begin
      next_cur.b_oreg = cur.b_latch;
    end
    // only new words go to the buffer, so a held output is not sent twice
    if (OUT_REG_B) begin
      next_cur.b_push  = b_adv & cur.b_fresh;
      next_cur.b_fresh = b_made | (cur.b_fresh & ~b_adv);
    end else begin
      next_cur.b_push  = b_made;
      next_cur.b_fresh = 1'b0;
    end

    // fifo pointers, bit granular so the two sides may differ in width
    if (f_wr) begin
      if (32'(cur.wptr) + WIDTH_A >= FIFO_CAP) begin
        next_cur.wptr  = erb_pkg::PTR_RESET;
        next_cur.wwrap = ~cur.wwrap;
      end else begin
        next_cur.wptr = cur.wptr + IW'(WIDTH_A);
      end
    end
    if (IS_FIFO && fifo_ctl.read_pointer_reset) begin
      // rewind for retransmit; the write side is left alone
      next_cur.rptr  = erb_pkg::PTR_RESET;
      next_cur.rwrap = next_cur.wwrap;
    end else if (f_rd) begin
      if (32'(cur.rptr) + WIDTH_B >= FIFO_CAP) begin
        next_cur.rptr  = erb_pkg::PTR_RESET;
        next_cur.rwrap = ~cur.rwrap;
      end else begin
        next_cur.rptr = cur.rptr + IW'(WIDTH_B);
      end
    end
    next_fill = fill_of(next_cur.wptr, next_cur.rptr, next_cur.wwrap, next_cur.rwrap);
    if (IS_FIFO) begin
      // thresholds count whole words of the side that owns the flag
      next_cur.flags.full_flag         = next_fill >=
        FW'(FW'(fifo_thr.full_level) * FW'(WIDTH_A));
      next_cur.flags.almost_full_flag  = next_fill >=
        FW'(FW'(fifo_thr.almost_full_level) * FW'(WIDTH_A));
      next_cur.flags.empty_flag        = next_fill < FW'(WIDTH_B);
      next_cur.flags.almost_empty_flag = next_fill <
        FW'(FW'(FW'(fifo_thr.almost_empty_level) + 1'b1) * FW'(WIDTH_B));
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      cur       <= '0;
      cur.flags <= erb_pkg::FLAGS_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ==========================================================================
  // array writes, captured straight from the port pins at the edge
  // contents survive reset, so a preload is never wiped; on a same-bit
  // collision of both ports, the one whose word starts lower is written last and wins, port b when both start at the same bit
  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < DW; i++) begin
      if (a_mask[i] && (int'(a_base) + i) < erb_pkg::CAP_BITS) begin
        mem[int'(a_base) + i] <= port_a.write_word_in[i];
      end
      if (b_mask[i] && (int'(b_base) + i) < erb_pkg::CAP_BITS) begin
        mem[int'(b_base) + i] <= port_b.write_word_in[i];
      end
    end
  end

  // ==========================================================================
  // port b words through the stream buffer
  erb_stream_fifo #(
    .WIDTH (DW),
    .DEPTH (erb_pkg::BUF_DEPTH),
    .SLACK (erb_pkg::BUF_SLACK)
  ) u_out_buf (
    .ref_clk   (ref_clk),
    .rstn      (rstn),
    .in_valid  (cur.b_push),
    .in_ready  (buf_ready),
    .in_data   (OUT_REG_B ? cur.b_oreg : cur.b_latch),
    .out_valid (b_rvalid),
    .out_ready (b_rready),
    .out_data  (b_rdata)
  );

  // ==========================================================================
  // outputs, each from a register
  assign a_rdata    = OUT_REG_A ? cur.a_oreg : cur.a_latch;
  assign b_ready    = buf_ready;
  assign fifo_flags = cur.flags;

endmodule : erb_embedded_ram_block

//--- erb_pkg.sv
// erb_pkg: shared constants, modes and carrier structs for the embedded ram block.
// assumes: one clock domain, synchronous active-low reset in every user.

package erb_pkg;

  // ==========================================================================
  // storage geometry
  localparam int CAP_BITS  = 9216;             // 9-Kbit array, 1024 x 9
  localparam int IDX_W     = 14;               // bit index into the array
  localparam int ADDR_W    = 13;               // widest word address (8192 x 1)
  localparam int DATA_W    = 18;               // widest port (512 x 18)
  localparam int LANE_W    = 9;                // one byte lane of an 18-bit word
  localparam int THR_W     = 13;               // flag threshold width, in words
  localparam int FILL_W    = 18;               // fill level and threshold products, in bits

  // ==========================================================================
  // output buffer geometry
  localparam int BUF_DEPTH = 32;               // words held after port b
  localparam int BUF_SLACK = 3;                // free slots kept for in-flight reads

  // ==========================================================================
  // reset values
  localparam logic [IDX_W-1:0]  PTR_RESET   = 14'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET  = 18'h00000;
  localparam logic [3:0]        FLAGS_RESET = 4'h3;  // empty and almost empty set

  // ==========================================================================
  // build-time choices
  typedef enum logic [3:0] {
    MODE_SINGLE      = 4'h1,
    MODE_TRUE_DUAL   = 4'h2,
    MODE_PSEUDO_DUAL = 4'h4,
    MODE_FIFO        = 4'h8
  } erb_mode_e;

  typedef enum logic [2:0] {
    WR_NORMAL     = 3'h1,                      // output keeps last read word
    WR_THROUGH    = 3'h2,                      // output shows the written word
    WR_READ_FIRST = 3'h4                       // output shows the old contents
  } erb_wmode_e;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic              clk_en;                 // port clock enable
    logic              sel;                    // port chip select
    logic              wr_en;                  // write, else read
    logic              output_register_enable; // advances the output register
    logic [1:0]        byte_lane_enable;       // lanes of an 18-bit write
    logic [ADDR_W-1:0] addr;                   // word address at port width
    logic [DATA_W-1:0] write_word_in;          // write data, low bits used
  } erb_port_req_s;

  typedef struct packed {
    logic write_port_select;
    logic write_select_alias;
    logic wr_en;
    logic read_port_select;
    logic read_select_alias;
    logic rd_en;
    logic output_read_enable;
    logic read_pointer_reset;
  } erb_fifo_ctl_s;

  typedef struct packed {
    logic [THR_W-1:0] full_level;              // write words
    logic [THR_W-1:0] almost_full_level;       // write words
    logic [THR_W-1:0] almost_empty_level;      // read words
  } erb_fifo_thr_s;

  typedef struct packed {
    logic almost_full_flag;
    logic full_flag;
    logic almost_empty_flag;
    logic empty_flag;
  } erb_fifo_flags_s;

  typedef struct packed {
    logic [DATA_W-1:0] a_latch;                // port a array output
    logic [DATA_W-1:0] a_oreg;                 // port a output register
    logic [DATA_W-1:0] b_latch;                // port b array output
    logic [DATA_W-1:0] b_oreg;                 // port b output register
    logic              b_fresh;                // b_latch holds unsent data
    logic              b_push;                 // word offered to the buffer
    logic [IDX_W-1:0]  wptr;                   // fifo write bit pointer
    logic [IDX_W-1:0]  rptr;                   // fifo read bit pointer
    logic              wwrap;                  // write lap parity
    logic              rwrap;                  // read lap parity
    erb_fifo_flags_s   flags;
  } erb_state_s;

  // words a port holds at a given width
  function automatic int depth_of(input int w);
    depth_of = (w == 18) ? 512 : ((w == 9) ? 1024 : 8192 / w);
  endfunction : depth_of

endpackage : erb_pkg

//--- erb_stream_sink.sv
// erb_stream_sink: fabric consumer of the port b stream, stalling on a pseudo-random beat.
// assumes: shares ref_clk with the ram block; hold stops all acceptance.
`timescale 1ns/1ps
// ==========
// consumer
module erb_stream_sink (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // stream and stall request
  input  wire logic hold,
  input  wire logic b_rvalid,
  output logic      b_rready
);
  logic [4:0] lfsr;  // stall beat, so the buffer sees slow draining too
  always_ff @(posedge ref_clk) begin
    if (!rstn) lfsr <= 5'h15;
    else lfsr <= {lfsr[3:0], lfsr[4] ^ lfsr[2]};
  end
  assign b_rready = rstn && !hold && b_rvalid && lfsr[0];  // active-high level
endmodule : erb_stream_sink

//--- tb_erb_embedded_ram_block.sv
// tb_erb_embedded_ram_block: dual-port and fifo instances driven from one sequence.
// assumes: stream sinks drain port b; expected words queue until they appear.
`timescale 1ns/1ps
module tb_erb_embedded_ram_block;
  logic ref_clk = 1'b0, rstn = 1'b0, hold = 1'b1, tk, v1, r1, k1, v2, r2, k2;
  erb_pkg::erb_port_req_s pa = '0, pb = '0, fa = '0;
  erb_pkg::erb_fifo_ctl_s fc = '0;
  erb_pkg::erb_fifo_thr_s fth = {13'h0006, 13'h0004, 13'h0002};  // full, almost full, almost empty
  erb_pkg::erb_fifo_flags_s g1, g2;
  logic [17:0] a1, d1, d2, m[8], q1[$], q2[$];
  logic [31:0] seed = 32'h00006de4;
  int error_cnt = 0, tests_run = 0;
  always #50 ref_clk = ~ref_clk;
  // port b reads before it writes; word 8 is preloaded and never written
  erb_embedded_ram_block #(.WMODE_A(erb_pkg::WR_THROUGH), .WMODE_B(erb_pkg::WR_READ_FIRST),
    .INIT(9216'h1a5 << 72)) u_erb_embedded_ram_block (
    .ref_clk(ref_clk), .rstn(rstn), .port_a(pa), .port_b(pb), .fifo_ctl('0), .fifo_thr('0),
    .a_rdata(a1), .b_rdata(d1), .b_rvalid(v1), .b_rready(r1), .b_ready(k1), .fifo_flags(g1));
  erb_embedded_ram_block #(.MODE(erb_pkg::MODE_FIFO)) u_erb_embedded_ram_block_fifo (
    .ref_clk(ref_clk), .rstn(rstn), .port_a(fa), .port_b('0), .fifo_ctl(fc), .fifo_thr(fth),
    .a_rdata(), .b_rdata(d2), .b_rvalid(v2), .b_rready(r2), .b_ready(k2), .fifo_flags(g2));
  erb_stream_sink u_erb_stream_sink (.ref_clk(ref_clk), .rstn(rstn), .hold(hold),
    .b_rvalid(v1), .b_rready(r1));
  erb_stream_sink u_erb_stream_sink_fifo (.ref_clk(ref_clk), .rstn(rstn), .hold(1'b0),
    .b_rvalid(v2), .b_rready(r2));
  function automatic logic [17:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[17:0] & 18'h001ff;  // nine-bit words only
  endfunction : rnd
  task automatic check(input string nm, input logic [17:0] seen, input logic [17:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic give_verdict();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task automatic drv_a(input logic w, input logic s, input logic [12:0] ad, input logic [17:0] dt);
    @(posedge ref_clk) #1 pa = '{1'b1, s, w, 1'b0, 2'b11, ad, dt};
    @(posedge ref_clk) #1 pa.clk_en = 1'b0;
  endtask : drv_a
  task automatic drv_b(input logic [12:0] ad, input logic w, input logic [17:0] dt);
    @(posedge ref_clk) #1 pb = '{1'b1, 1'b1, w, 1'b0, 2'b11, ad, dt};
    tk = k1;  // ready as it stands at the taking edge
    @(posedge ref_clk) if (tk) q1.push_back(m[ad[2:0]]);  // old word, read or overwritten
    #1 pb.clk_en = 1'b0;
  endtask : drv_b
  task automatic drv_f(input logic [7:0] c, input logic [17:0] dt);
    @(posedge ref_clk) #1 fc = c;
    fa.write_word_in = dt;
    @(posedge ref_clk) #1 fc = '0;
  endtask : drv_f
  // monitor: each accepted stream word against the oldest note
  // sampled mid-cycle, where the handshake for the next edge has settled
  always @(negedge ref_clk) begin
    if (rstn && v1 && r1) check("b dual", d1, q1.size() ? q1.pop_front() : ~d1);
    if (rstn && v2 && r2) check("b fifo", d2, q2.size() ? q2.pop_front() : ~d2);
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    #1 rstn = 1'b1;
    check("a reset", a1, 18'h00000);
    check("flags reset", {14'h0000, g2}, 18'h00003);
    hold = 1'b0;
    for (int i = 0; i < 8; i++) begin
      m[i] = rnd();
      drv_a(1'b1, 1'b1, i[12:0], m[i]);
      check("thru", a1, m[i]);
    end
    drv_a(1'b1, 1'b0, 13'h0000, m[0] ^ 18'h001ff);
    check("held", a1, m[7]);
    drv_a(1'b0, 1'b1, 13'h0008, 18'h00000);
    check("rom", a1, 18'h001a5);
    for (int i = 0; i < 8; i++) begin
      drv_a(1'b0, 1'b1, i[12:0], 18'h00000);
      check("read a", a1, m[i]);
      drv_b(i[12:0], 1'b0, 18'h00000);
    end
    drv_b(13'h0002, 1'b1, m[2] ^ 18'h00100);
    m[2] = m[2] ^ 18'h00100;
    drv_a(1'b0, 1'b1, 13'h0002, 18'h00000);
    check("b write", a1, m[2]);
    // stalled sink: buffer fills until port b refuses
    hold = 1'b1;
    for (int i = 0; i < 40; i++) drv_b(13'h0003, 1'b0, 18'h00000);
    check("b refused", {17'h00000, k1}, 18'h00000);
    hold = 1'b0;
    drv_f(8'ha0, 18'h00055);
    @(posedge ref_clk) #1 check("alias", {14'h0000, g2}, 18'h00003);
    for (int i = 0; i < 8; i++) begin
      m[i] = rnd();
      drv_f(8'he0, m[i]);
    end
    @(posedge ref_clk) #1 check("full", {14'h0000, g2}, 18'h0000c);
    for (int j = 0; j < 2; j++) begin
      drv_f(8'h14, 18'h00000);
      for (int i = 0; i < 8; i++) begin
        drv_f(8'h1c, 18'h00000);
        if (i < 6) q2.push_back(m[i]);
      end
      @(posedge ref_clk) #1 check("empty", {14'h0000, g2}, 18'h00003);
      drv_f(8'h01, 18'h00000);
      @(posedge ref_clk) #1 check("rewind", {14'h0000, g2}, 18'h0000c);
    end
    for (int t = 0; t < 500 && (q1.size() || q2.size()); t++) @(posedge ref_clk);
    if (q1.size() || q2.size()) error_cnt++;
    give_verdict();
  end
endmodule : tb_erb_embedded_ram_block
